// ==== shared/aot_pkg.sv ====
// Constants, register map and types for the offset-trim register bank
//
// Summary of operation
// - Core 0, input 1, dual mode, calibration on: apply trim at index 0x346.
// - Core 0, input 0, single mode, calibration on: apply trim at index 0x348.
// - Core 0, input 1, 90-degree phase, single mode: apply trim at index 0x34A.
// - Core 1 sampling input 0, calibration on, either mode: apply index 0x34C.
// - Core 1 sampling input 1, calibration on, either mode: apply index 0x34E.
// - Each trim is 16 bits; 15:12 reserved read/write; 11:0 offset; reset zero.
// - Trims load a fused default after reset; software reads and overwrites it.
`default_nettype none
package aot_pkg;
   // Geometry
   localparam int AOT_NUM_TRIM = 5;
   localparam int AOT_REG_W    = 16;
   localparam int AOT_OFS_W    = 12;
   localparam int AOT_ADDR_W   = 12;
   localparam int AOT_DATA_W   = 32;

   // Register indices; byte address is four times the index
   localparam logic [9:0] AOT_IDX_C0_DUAL_IN1   = 10'h346;
   localparam logic [9:0] AOT_IDX_C0_SINGLE_IN0 = 10'h348;
   localparam logic [9:0] AOT_IDX_C0_SINGLE_IN1 = 10'h34A;
   localparam logic [9:0] AOT_IDX_C1_IN0        = 10'h34C;
   localparam logic [9:0] AOT_IDX_C1_IN1        = 10'h34E;

   // Control and status byte addresses
   localparam logic [11:0] AOT_ADDR_CTRL   = 12'h000;
   localparam logic [11:0] AOT_ADDR_STATUS = 12'h004;

   // Control fields
   localparam int AOT_CTRL_FG_EN_BIT  = 0;
   localparam int AOT_CTRL_DUAL_BIT   = 1;
   localparam int AOT_CTRL_RELOAD_BIT = 2;
   localparam logic [1:0] AOT_CTRL_RESET = 2'h0;

   // Status fields
   localparam int AOT_STAT_DONE_BIT  = 0;
   localparam int AOT_STAT_C0_ON_BIT = 1;
   localparam int AOT_STAT_C1_ON_BIT = 2;

   // Trim fields and reset
   localparam int AOT_TRIM_OFS_MSB = 11;
   localparam logic [15:0] AOT_TRIM_RESET = 16'h0000;

   // Decoded slots
   localparam logic [2:0] AOT_SLOT_C0_DUAL_IN1   = 3'h0;
   localparam logic [2:0] AOT_SLOT_C0_SINGLE_IN0 = 3'h1;
   localparam logic [2:0] AOT_SLOT_C0_SINGLE_IN1 = 3'h2;
   localparam logic [2:0] AOT_SLOT_C1_IN0        = 3'h3;
   localparam logic [2:0] AOT_SLOT_C1_IN1        = 3'h4;
   localparam logic [2:0] AOT_SLOT_CTRL          = 3'h5;
   localparam logic [2:0] AOT_SLOT_STATUS        = 3'h6;
   localparam logic [2:0] AOT_SLOT_NONE          = 3'h7;

   // Bus responses
   localparam logic [1:0] AOT_RESP_OKAY   = 2'h0;
   localparam logic [1:0] AOT_RESP_SLVERR = 2'h2;

   // Fused-default loader states
   typedef enum logic [1:0] {
      AOT_ST_IDLE = 2'b00,
      AOT_ST_LOAD = 2'b01,
      AOT_ST_RUN  = 2'b11
   } aot_fuse_st_t;
endpackage
`default_nettype wire

// ==== design/aot_axil_slave.sv ====
// AXI4-Lite slave handshake for the offset-trim register bank
`timescale 1ns/1ps
`default_nettype none
module aot_axil_slave (
   // Clock and reset
   input  wire logic        aclk,
   input  wire logic        aresetn,
   // Write address and data
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   // Write response
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   // Read address and data
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   // Register file side
   output logic             wr_en,
   output logic [11:0]      wr_addr,
   output logic [31:0]      wr_data,
   output logic [3:0]       wr_strb,
   input  wire logic        wr_err,
   output logic             rd_en,
   output logic [11:0]      rd_addr,
   input  wire logic [31:0] rd_data,
   input  wire logic        rd_err
);
   logic aw_full_q;
   logic w_full_q;
   logic bvalid_q;
   logic rvalid_q;
   logic [1:0]  bresp_q;
   logic [1:0]  rresp_q;
   logic [31:0] rdata_q;

   // Channel readies and strobes
   assign s_axi_awready = !aw_full_q && !bvalid_q;
   assign s_axi_wready  = !w_full_q && !bvalid_q;
   assign s_axi_arready = !rvalid_q;
   assign wr_en         = aw_full_q && w_full_q;
   assign rd_en         = s_axi_arvalid && !rvalid_q;
   assign rd_addr       = s_axi_araddr;
   assign s_axi_bvalid  = bvalid_q;
   assign s_axi_bresp   = bresp_q;
   assign s_axi_rvalid  = rvalid_q;
   assign s_axi_rresp   = rresp_q;
   assign s_axi_rdata   = rdata_q;

   // Address and data capture, either order
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
         wr_addr   <= 12'h000;
         wr_data   <= 32'h0000_0000;
         wr_strb   <= 4'h0;
      end else if (wr_en) begin
         aw_full_q <= 1'b0;
         w_full_q  <= 1'b0;
      end else begin
         if (s_axi_awvalid && s_axi_awready) begin
            aw_full_q <= 1'b1;
            wr_addr   <= s_axi_awaddr;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_full_q <= 1'b1;
            wr_data  <= s_axi_wdata;
            wr_strb  <= s_axi_wstrb;
         end
      end
   end

   // Write response after both halves are in
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         bvalid_q <= 1'b0;
         bresp_q  <= aot_pkg::AOT_RESP_OKAY;
      end else if (wr_en) begin
         bvalid_q <= 1'b1;
         bresp_q  <= wr_err ? aot_pkg::AOT_RESP_SLVERR : aot_pkg::AOT_RESP_OKAY;
      end else if (s_axi_bready) begin
         bvalid_q <= 1'b0;
      end
   end

   // Read answer one cycle after the address is taken
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rresp_q  <= aot_pkg::AOT_RESP_OKAY;
         rdata_q  <= 32'h0000_0000;
      end else if (rd_en) begin
         rvalid_q <= 1'b1;
         rresp_q  <= rd_err ? aot_pkg::AOT_RESP_SLVERR : aot_pkg::AOT_RESP_OKAY;
         rdata_q  <= rd_data;
      end else if (s_axi_rready) begin
         rvalid_q <= 1'b0;
      end
   end
endmodule
`default_nettype wire

// ==== design/aot_trim_regs.sv ====
// Offset-trim register bank with fused defaults and datapath selection
//
// Local design decision: register access over AXI4-Lite.
`timescale 1ns/1ps
`default_nettype none
module aot_trim_regs #(
   parameter int NUM_TRIM = aot_pkg::AOT_NUM_TRIM
) (
   // Clock and reset
   input  wire logic                   aclk,
   input  wire logic                   aresetn,
   // AXI4-Lite write address and data
   input  wire logic [11:0]            s_axi_awaddr,
   input  wire logic                   s_axi_awvalid,
   output logic                        s_axi_awready,
   input  wire logic [31:0]            s_axi_wdata,
   input  wire logic [3:0]             s_axi_wstrb,
   input  wire logic                   s_axi_wvalid,
   output logic                        s_axi_wready,
   // AXI4-Lite write response
   output logic [1:0]                  s_axi_bresp,
   output logic                        s_axi_bvalid,
   input  wire logic                   s_axi_bready,
   // AXI4-Lite read
   input  wire logic [11:0]            s_axi_araddr,
   input  wire logic                   s_axi_arvalid,
   output logic                        s_axi_arready,
   output logic [31:0]                 s_axi_rdata,
   output logic [1:0]                  s_axi_rresp,
   output logic                        s_axi_rvalid,
   input  wire logic                   s_axi_rready,
   // Fused defaults, slot 0 in the low word
   input  wire logic [NUM_TRIM*16-1:0] fuse_trim_default,
   // Sampling state from the converter cores
   input  wire logic                   core0_input_sel,
   input  wire logic                   core0_phase90,
   input  wire logic                   core1_input_sel,
   // Offsets to the datapath
   output logic [11:0]                 core0_offset,
   output logic                        core0_offset_on,
   output logic [11:0]                 core1_offset,
   output logic                        core1_offset_on,
   output logic                        fuse_load_done
);
   logic        wr_en;
   logic [11:0] wr_addr;
   logic [31:0] wr_data;
   logic [3:0]  wr_strb;
   logic        wr_err;
   logic        rd_en;
   logic [11:0] rd_addr;
   logic [31:0] rd_data;
   logic        rd_err;

   logic [15:0] trim_q [NUM_TRIM];
   logic        fg_en_q;
   logic        dual_q;
   logic        reload_d;
   logic [2:0]  wr_slot;
   logic [2:0]  rd_slot;
   logic [2:0]  core0_slot;
   logic [2:0]  core1_slot;
   logic [11:0] core0_offset_q;
   logic [11:0] core1_offset_q;
   logic        core0_on_q;
   logic        core1_on_q;

   aot_pkg::aot_fuse_st_t st_q;
   aot_pkg::aot_fuse_st_t st_d;

   // Byte address to register slot
   function automatic logic [2:0] aot_addr_slot(input logic [11:0] a);
      logic [2:0] s;
      s = aot_pkg::AOT_SLOT_NONE;
      case (a)
         {aot_pkg::AOT_IDX_C0_DUAL_IN1, 2'b00}:   s = aot_pkg::AOT_SLOT_C0_DUAL_IN1;
         {aot_pkg::AOT_IDX_C0_SINGLE_IN0, 2'b00}: s = aot_pkg::AOT_SLOT_C0_SINGLE_IN0;
         {aot_pkg::AOT_IDX_C0_SINGLE_IN1, 2'b00}: s = aot_pkg::AOT_SLOT_C0_SINGLE_IN1;
         {aot_pkg::AOT_IDX_C1_IN0, 2'b00}:        s = aot_pkg::AOT_SLOT_C1_IN0;
         {aot_pkg::AOT_IDX_C1_IN1, 2'b00}:        s = aot_pkg::AOT_SLOT_C1_IN1;
         aot_pkg::AOT_ADDR_CTRL:                  s = aot_pkg::AOT_SLOT_CTRL;
         aot_pkg::AOT_ADDR_STATUS:                s = aot_pkg::AOT_SLOT_STATUS;
         default:                                 s = aot_pkg::AOT_SLOT_NONE;
      endcase
      return s;
   endfunction

   // Which trim a core uses for its present sampling state
   function automatic logic [2:0] aot_pick(input logic core1,
                                           input logic in1,
                                           input logic ph90,
                                           input logic dual);
      logic [2:0] s;
      s = aot_pkg::AOT_SLOT_NONE;
      if (core1) begin
         s = in1 ? aot_pkg::AOT_SLOT_C1_IN1
                 : aot_pkg::AOT_SLOT_C1_IN0;
      end else if (dual) begin
         if (in1) begin
            s = aot_pkg::AOT_SLOT_C0_DUAL_IN1;
         end
      end else if (!in1) begin
         s = aot_pkg::AOT_SLOT_C0_SINGLE_IN0;
      end else if (ph90) begin
         s = aot_pkg::AOT_SLOT_C0_SINGLE_IN1;
      end
      return s;
   endfunction

   // Byte-lane merge into a 16-bit register
   function automatic logic [15:0] aot_merge(input logic [15:0] old,
                                             input logic [31:0] d,
                                             input logic [3:0]  strb);
      logic [15:0] r;
      r = old;
      if (strb[0]) begin
         r[7:0] = d[7:0];
      end
      if (strb[1]) begin
         r[15:8] = d[15:8];
      end
      return r;
   endfunction

   // Bus handshake
   aot_axil_slave u_slave (
      .aclk          (aclk),
      .aresetn       (aresetn),
      .s_axi_awaddr  (s_axi_awaddr),
      .s_axi_awvalid (s_axi_awvalid),
      .s_axi_awready (s_axi_awready),
      .s_axi_wdata   (s_axi_wdata),
      .s_axi_wstrb   (s_axi_wstrb),
      .s_axi_wvalid  (s_axi_wvalid),
      .s_axi_wready  (s_axi_wready),
      .s_axi_bresp   (s_axi_bresp),
      .s_axi_bvalid  (s_axi_bvalid),
      .s_axi_bready  (s_axi_bready),
      .s_axi_araddr  (s_axi_araddr),
      .s_axi_arvalid (s_axi_arvalid),
      .s_axi_arready (s_axi_arready),
      .s_axi_rdata   (s_axi_rdata),
      .s_axi_rresp   (s_axi_rresp),
      .s_axi_rvalid  (s_axi_rvalid),
      .s_axi_rready  (s_axi_rready),
      .wr_en         (wr_en),
      .wr_addr       (wr_addr),
      .wr_data       (wr_data),
      .wr_strb       (wr_strb),
      .wr_err        (wr_err),
      .rd_en         (rd_en),
      .rd_addr       (rd_addr),
      .rd_data       (rd_data),
      .rd_err        (rd_err)
   );

   // Address decode
   assign wr_slot  = aot_addr_slot(wr_addr);
   assign rd_slot  = aot_addr_slot(rd_addr);
   assign wr_err   = (wr_slot == aot_pkg::AOT_SLOT_NONE);
   assign rd_err   = (rd_slot == aot_pkg::AOT_SLOT_NONE);
   assign reload_d = wr_en && (wr_slot == aot_pkg::AOT_SLOT_CTRL) && wr_strb[0]
                     && wr_data[aot_pkg::AOT_CTRL_RELOAD_BIT];

   // Fused-default loader sequence
   always_comb begin
      st_d = st_q;
      case (st_q)
         aot_pkg::AOT_ST_IDLE: st_d = aot_pkg::AOT_ST_LOAD;
         aot_pkg::AOT_ST_LOAD: st_d = aot_pkg::AOT_ST_RUN;
         aot_pkg::AOT_ST_RUN: begin
            if (reload_d) begin
               st_d = aot_pkg::AOT_ST_LOAD;
            end
         end
         default: st_d = aot_pkg::AOT_ST_IDLE;
      endcase
   end

   // Loader state register
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         st_q <= aot_pkg::AOT_ST_IDLE;
      end else begin
         st_q <= st_d;
      end
   end

   // Trim storage: zero at reset, fused default on load, then bus writes
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         for (int i = 0; i < NUM_TRIM; i++) begin
            trim_q[i] <= aot_pkg::AOT_TRIM_RESET;
         end
      end else if (st_q == aot_pkg::AOT_ST_LOAD) begin
         for (int i = 0; i < NUM_TRIM; i++) begin
            trim_q[i] <= fuse_trim_default[i*16 +: 16];
         end
      end else if (wr_en && (wr_slot < aot_pkg::AOT_SLOT_CTRL)) begin
         trim_q[wr_slot] <= aot_merge(trim_q[wr_slot], wr_data, wr_strb);
      end
   end

   // Control register: calibration enable and channel mode
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         fg_en_q <= aot_pkg::AOT_CTRL_RESET[aot_pkg::AOT_CTRL_FG_EN_BIT];
         dual_q  <= aot_pkg::AOT_CTRL_RESET[aot_pkg::AOT_CTRL_DUAL_BIT];
      end else if (wr_en && (wr_slot == aot_pkg::AOT_SLOT_CTRL) && wr_strb[0]) begin
         fg_en_q <= wr_data[aot_pkg::AOT_CTRL_FG_EN_BIT];
         dual_q  <= wr_data[aot_pkg::AOT_CTRL_DUAL_BIT];
      end
   end

   // Read data mux; upper bits read zero
   always_comb begin
      rd_data = 32'h0000_0000;
      case (rd_slot)
         aot_pkg::AOT_SLOT_CTRL: begin
            rd_data[aot_pkg::AOT_CTRL_FG_EN_BIT] = fg_en_q;
            rd_data[aot_pkg::AOT_CTRL_DUAL_BIT]  = dual_q;
         end
         aot_pkg::AOT_SLOT_STATUS: begin
            rd_data[aot_pkg::AOT_STAT_DONE_BIT]  = (st_q == aot_pkg::AOT_ST_RUN);
            rd_data[aot_pkg::AOT_STAT_C0_ON_BIT] = core0_on_q;
            rd_data[aot_pkg::AOT_STAT_C1_ON_BIT] = core1_on_q;
         end
         aot_pkg::AOT_SLOT_NONE: rd_data = 32'h0000_0000;
         default: rd_data[15:0] = trim_q[rd_slot];
      endcase
   end

   // Trim selection per core
   assign core0_slot = aot_pick(1'b0, core0_input_sel, core0_phase90, dual_q);
   assign core1_slot = aot_pick(1'b1, core1_input_sel, 1'b0, dual_q);

   // Applied offsets, only with foreground calibration on
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         core0_offset_q <= 12'h000;
         core0_on_q     <= 1'b0;
         core1_offset_q <= 12'h000;
         core1_on_q     <= 1'b0;
      end else begin
         core0_on_q     <= fg_en_q && (core0_slot != aot_pkg::AOT_SLOT_NONE);
         core1_on_q     <= fg_en_q;
         core0_offset_q <= 12'h000;
         core1_offset_q <= 12'h000;
         if (fg_en_q && (core0_slot != aot_pkg::AOT_SLOT_NONE)) begin
            core0_offset_q <= trim_q[core0_slot][aot_pkg::AOT_TRIM_OFS_MSB:0];
         end
         if (fg_en_q) begin
            core1_offset_q <= trim_q[core1_slot][aot_pkg::AOT_TRIM_OFS_MSB:0];
         end
      end
   end

   // Outputs
   assign core0_offset    = core0_offset_q;
   assign core0_offset_on = core0_on_q;
   assign core1_offset    = core1_offset_q;
   assign core1_offset_on = core1_on_q;
   assign fuse_load_done  = (st_q == aot_pkg::AOT_ST_RUN);
endmodule
`default_nettype wire

// ==== tb/aot_trim_regs_monitor.sv ====
// Bus handshake and offset output checker for the trim bank
`timescale 1ns/1ps
`default_nettype none
module aot_trim_regs_monitor #(
   parameter int NUM_TRIM = 5
) (
   // Clock and reset
   input wire logic        aclk,
   input wire logic        aresetn,
   // Write channels
   input wire logic        s_axi_awvalid,
   input wire logic        s_axi_awready,
   input wire logic        s_axi_wvalid,
   input wire logic        s_axi_wready,
   input wire logic [1:0]  s_axi_bresp,
   input wire logic        s_axi_bvalid,
   input wire logic        s_axi_bready,
   // Read channels
   input wire logic        s_axi_arvalid,
   input wire logic        s_axi_arready,
   input wire logic [31:0] s_axi_rdata,
   input wire logic [1:0]  s_axi_rresp,
   input wire logic        s_axi_rvalid,
   input wire logic        s_axi_rready,
   // Datapath side
   input wire logic [11:0] core0_offset,
   input wire logic        core0_offset_on,
   input wire logic [11:0] core1_offset,
   input wire logic        core1_offset_on,
   input wire logic        fuse_load_done
);
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   // Handshake holding and spacing
   a_rvalid_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid
      && $stable(s_axi_rdata) && $stable(s_axi_rresp)) else $error("read answer not held");
   a_bvalid_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid
      && $stable(s_axi_bresp)) else $error("write answer not held");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read answer late");
   a_read_block: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   a_write_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while answer pending");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |-> ##[1:2] s_axi_bvalid) else $error("write answer late");
   // Fused defaults and offset outputs
   a_load_after_reset: assert property ($rose(aresetn) |-> ##[1:4] fuse_load_done)
      else $error("fused load not done");
   a_offset_idle_zero: assert property ((!core0_offset_on |-> core0_offset == 12'h000)
      and (!core1_offset_on |-> core1_offset == 12'h000)) else $error("offset without on");
   a_core1_with_core0: assert property (core0_offset_on |-> core1_offset_on)
      else $error("core1 offset off while calibrating");

   // Main scenarios
   c_both_on: cover property (core0_offset_on && core1_offset_on);
   c_read_error: cover property (s_axi_rvalid && s_axi_rresp == 2'h2);
   c_load_done: cover property ($rose(fuse_load_done));
endmodule
bind aot_trim_regs aot_trim_regs_monitor #(.NUM_TRIM(NUM_TRIM)) aot_trim_regs_monitor_i (
   .aclk(aclk), .aresetn(aresetn), .s_axi_awvalid(s_axi_awvalid),
   .s_axi_awready(s_axi_awready), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
   .core0_offset(core0_offset), .core0_offset_on(core0_offset_on),
   .core1_offset(core1_offset), .core1_offset_on(core1_offset_on),
   .fuse_load_done(fuse_load_done));
`default_nettype wire

// ==== tb/test_aot_trim_regs.sv ====
// Self-checking bench for the offset-trim register bank
`timescale 1ns/1ps
`default_nettype none
module test_aot_trim_regs;
   logic        aclk              = 1'b0;
   logic        aresetn           = 1'b0;
   logic [11:0] s_axi_awaddr      = 12'h000;
   logic        s_axi_awvalid     = 1'b0;
   logic [31:0] s_axi_wdata       = 32'h0;
   logic [3:0]  s_axi_wstrb       = 4'h0;
   logic        s_axi_wvalid      = 1'b0;
   logic        s_axi_bready      = 1'b0;
   logic [11:0] s_axi_araddr      = 12'h000;
   logic        s_axi_arvalid     = 1'b0;
   logic        s_axi_rready      = 1'b0;
   logic [79:0] fuse_trim_default = 80'h0;
   logic        core0_input_sel   = 1'b0;
   logic        core0_phase90     = 1'b0;
   logic        core1_input_sel   = 1'b0;
   logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
   logic [1:0]  s_axi_bresp, s_axi_rresp;
   logic [31:0] s_axi_rdata;
   logic [11:0] core0_offset, core1_offset;
   logic        core0_offset_on, core1_offset_on, fuse_load_done;
   logic [15:0] trim_m [5];
   int          bad_count         = 0;
   int          compares          = 0;
   localparam logic [9:0] IDX [5] = '{aot_pkg::AOT_IDX_C0_DUAL_IN1,
      aot_pkg::AOT_IDX_C0_SINGLE_IN0, aot_pkg::AOT_IDX_C0_SINGLE_IN1,
      aot_pkg::AOT_IDX_C1_IN0, aot_pkg::AOT_IDX_C1_IN1};

   aot_trim_regs #(.NUM_TRIM(5)) aot_trim_regs_i (.aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
      .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb), .s_axi_wvalid(s_axi_wvalid),
      .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid),
      .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr), .s_axi_arvalid(s_axi_arvalid),
      .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
      .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
      .fuse_trim_default(fuse_trim_default), .core0_input_sel(core0_input_sel),
      .core0_phase90(core0_phase90), .core1_input_sel(core1_input_sel),
      .core0_offset(core0_offset), .core0_offset_on(core0_offset_on),
      .core1_offset(core1_offset), .core1_offset_on(core1_offset_on),
      .fuse_load_done(fuse_load_done));

   // 50 MHz clock
   always #10 aclk = ~aclk;

   // Random source
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {1'b0, x[31:1]} ^ (x[0] ? 32'h80200003 : 32'h0);
   endfunction

   // Expected core offsets as {on, offset}
   function automatic logic [12:0] exp_c0(input logic fg, dual, in1, ph);
      if (!fg || (dual && !in1) || (!dual && in1 && !ph)) return 13'h0000;
      if (dual) return {1'b1, trim_m[0][11:0]};
      return {1'b1, in1 ? trim_m[2][11:0] : trim_m[1][11:0]};
   endfunction
   function automatic logic [12:0] exp_c1(input logic fg, in1);
      return fg ? {1'b1, in1 ? trim_m[4][11:0] : trim_m[3][11:0]} : 13'h0000;
   endfunction

   // Comparisons
   task automatic chk_bus(input string what, input logic [31:0] exp, input logic [31:0] got);
      compares++;
      if (got !== exp) begin
         $display("wrong value %s expected %h seen %h", what, exp, got);
         bad_count++;
      end
   endtask
   task automatic chk_dp(input string what, input logic [12:0] exp, input logic [12:0] got);
      chk_bus(what, {19'h0, exp}, {19'h0, got});
   endtask

   // Bus write, both halves offered together
   task automatic bus_wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                         output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_awvalid <= 1'b1;
      s_axi_wdata <= d;
      s_axi_wstrb <= s;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      r = 2'h3;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_awready) s_axi_awvalid <= 1'b0;
         if (s_axi_wready) s_axi_wvalid <= 1'b0;
         if (s_axi_bvalid) begin
            r = s_axi_bresp;
            break;
         end
      end
      s_axi_bready <= 1'b0;
      if (n == 64) bad_count++;
   endtask

   // Bus read
   task automatic bus_rd(input logic [11:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      r = 2'h3;
      d = 32'h0;
      for (n = 0; n < 64; n++) begin
         @(posedge aclk);
         if (s_axi_arready) s_axi_arvalid <= 1'b0;
         if (s_axi_rvalid) begin
            d = s_axi_rdata;
            r = s_axi_rresp;
            break;
         end
      end
      s_axi_rready <= 1'b0;
      if (n == 64) bad_count++;
   endtask

   // Read back every trim against the model
   task automatic chk_trims;
      logic [31:0] d;
      logic [1:0]  r;
      for (int i = 0; i < 5; i++) begin
         bus_rd({IDX[i], 2'b00}, d, r);
         chk_bus("trim value", {16'h0, trim_m[i]}, d);
         chk_bus("trim resp", {30'h0, aot_pkg::AOT_RESP_OKAY}, {30'h0, r});
      end
   endtask

   task automatic end_sim;
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   // Hang guard
   initial begin
      repeat (20000) @(posedge aclk);
      bad_count++;
      end_sim;
   end

   // Main sequence
   initial begin
      logic [31:0] rng, d;
      logic [79:0] f;
      logic [3:0]  s;
      logic [1:0]  r;
      logic [12:0] e0, e1;
      rng = 32'h3D440721;
      for (int i = 0; i < 5; i++) begin
         rng = lfsr(rng);
         f[16*i +: 16] = rng[15:0];
      end
      repeat (16) @(posedge aclk);
      fuse_trim_default <= f;
      aresetn <= 1'b1;
      for (int n = 0; n < 50 && fuse_load_done !== 1'b1; n++) @(posedge aclk);
      chk_bus("load done", 32'h1, {31'h0, fuse_load_done});
      for (int i = 0; i < 5; i++) trim_m[i] = f[16*i +: 16];
      chk_trims;
      bus_rd(aot_pkg::AOT_ADDR_CTRL, d, r);
      chk_bus("ctrl reset", 32'h0, d);
      $display("test fused defaults done");
      // Random writes with partial strobes, reserved bits included
      for (int k = 0; k < 20; k++) begin
         rng = lfsr(rng);
         s = (k < 5) ? 4'hF : rng[19:16];
         bus_wr({IDX[k % 5], 2'b00}, rng, s, r);
         chk_bus("write resp", {30'h0, aot_pkg::AOT_RESP_OKAY}, {30'h0, r});
         if (s[0]) trim_m[k % 5][7:0] = rng[7:0];
         if (s[1]) trim_m[k % 5][15:8] = rng[15:8];
      end
      chk_trims;
      $display("test write readback done");
      // Unmapped places, one inside the trim range
      for (int k = 0; k < 2; k++) begin
         bus_wr(k ? 12'hD1C : 12'h100, 32'hFFFF, 4'hF, r);
         chk_bus("unmapped write", {30'h0, aot_pkg::AOT_RESP_SLVERR}, {30'h0, r});
         bus_rd(k ? 12'hD1C : 12'h100, d, r);
         chk_bus("unmapped read", 32'h0, d);
         chk_bus("unmapped resp", {30'h0, aot_pkg::AOT_RESP_SLVERR}, {30'h0, r});
      end
      chk_trims;
      $display("test unmapped done");
      // Every mode, calibration, input and phase combination
      for (int k = 0; k < 32; k++) begin
         bus_wr(aot_pkg::AOT_ADDR_CTRL, {30'h0, k[0], k[1]}, 4'h1, r);
         @(posedge aclk);
         core0_input_sel <= k[2];
         core0_phase90 <= k[3];
         core1_input_sel <= k[4];
         repeat (2) @(posedge aclk);
         #1;
         e0 = exp_c0(k[1], k[0], k[2], k[3]);
         e1 = exp_c1(k[1], k[4]);
         chk_dp("core0 offset", e0, {core0_offset_on, core0_offset});
         chk_dp("core1 offset", e1, {core1_offset_on, core1_offset});
         bus_rd(aot_pkg::AOT_ADDR_STATUS, d, r);
         chk_bus("status", {29'h0, e1[12], e0[12], 1'b1}, d);
      end
      $display("test datapath selection done");
      // Reload of fresh fused defaults over written values
      for (int i = 0; i < 5; i++) begin
         rng = lfsr(rng);
         f[16*i +: 16] = rng[15:0];
         trim_m[i] = rng[15:0];
      end
      @(posedge aclk);
      fuse_trim_default <= f;
      bus_wr(aot_pkg::AOT_ADDR_CTRL, 32'h4, 4'h1, r);
      repeat (4) @(posedge aclk);
      chk_trims;
      $display("test reload done");
      end_sim;
   end
endmodule
`default_nettype wire
